// ### core/vcr_config_one.sv
`timescale 1ns/1ps
module vcr_config_one
   import vcr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic swReset,
   input wire logic loadDefaults,
   input wire vcr_defaults_t defaults,
   input wire logic fourLineInstr,
   input wire logic guardPinMode,
   input wire logic spiClk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic wpPinIn,
   input wire logic line3PinIn,
   output logic misoOut,
   output logic misoOe,
   output logic [7:0] cfgOne,
   output vcr_status_t status,
   output logic guardedWriteOk,
   output logic line3IsData,
   output logic hwResetN
);
   // ----------------------------------------------------------------
   // Synchronisers for pins and defaults into core domain
   // ----------------------------------------------------------------
   logic [1:0] csSync_r, csSync_nxt;
   logic [1:0] wpSync_r, wpSync_nxt;
   logic [1:0] l3Sync_r, l3Sync_nxt;
   vcr_defaults_t defS1_r, defS1_nxt, defS2_r, defS2_nxt;

   always_comb begin
      csSync_nxt = {csSync_r[0], csN};
      wpSync_nxt = {wpSync_r[0], wpPinIn};
      l3Sync_nxt = {l3Sync_r[0], line3PinIn};
      defS1_nxt = defaults;
      defS2_nxt = defS1_r;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         csSync_r <= 2'h3;
         wpSync_r <= 2'h3;
         l3Sync_r <= 2'h3;
         defS1_r <= vcr_defaults_t'(8'h00);
         defS2_r <= vcr_defaults_t'(8'h00);
      end else begin
         csSync_r <= csSync_nxt;
         wpSync_r <= wpSync_nxt;
         l3Sync_r <= l3Sync_nxt;
         defS1_r <= defS1_nxt;
         defS2_r <= defS2_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link side shifter, clocked by the host's serial clock
   // ----------------------------------------------------------------
   // Runs only inside frames; csN high clears state asynchronously.
   logic [5:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] opcode_r, opcode_nxt;
   logic [31:0] shift_r, shift_nxt;
   logic wrEnVol_r, wrEnVol_nxt;
   logic [7:0] capByte_r, capByte_nxt;
   logic capKind_r, capKind_nxt;
   logic capTgl_r, capTgl_nxt;
   logic [7:0] txByte_r, txByte_nxt;
   logic [7:0] readSnap1_r, readSnap1_nxt, readSnap2_r, readSnap2_nxt;
   logic capArm_r, capArm_nxt;

   always_comb begin
      bitCnt_nxt = (bitCnt_r == 6'h3F) ? bitCnt_r : bitCnt_r + 6'h01;
      shift_nxt = {shift_r[30:0], mosi};
      opcode_nxt = opcode_r;
      capByte_nxt = capByte_r;
      capKind_nxt = capKind_r;
      capArm_nxt = capArm_r;
      if (bitCnt_r == 6'd7) begin
         opcode_nxt = {shift_r[6:0], mosi};
      end
      // Write-registers: second data byte is this register
      if (opcode_r == VCR_OP_WRITE_REGS && bitCnt_r == 6'd23) begin
         capByte_nxt = {shift_r[6:0], mosi};
         capKind_nxt = 1'b0;
         capArm_nxt = wrEnVol_r;
      end
      // Write-any: 24-bit address then data byte
      if (opcode_r == VCR_OP_WRITE_ANY && bitCnt_r == 6'd39) begin
         capByte_nxt = {shift_r[6:0], mosi};
         capKind_nxt = 1'b1;
         capArm_nxt = wrEnVol_r && (shift_r[30:7] == VCR_ADDR_CFG1);
      end
   end

   always_ff @(posedge spiClk or posedge csN) begin
      if (csN) begin
         bitCnt_r <= 6'h00;
         opcode_r <= 8'h00;
         shift_r <= 32'h0000_0000;
         capArm_r <= 1'b0;
         capByte_r <= 8'h00;
         capKind_r <= 1'b0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         opcode_r <= opcode_nxt;
         shift_r <= shift_nxt;
         capArm_r <= capArm_nxt;
         capByte_r <= capByte_nxt;
         capKind_r <= capKind_nxt;
      end
   end

   // Commit request toggles on the select rise, after a full frame
   logic frameOk;
   assign frameOk = capArm_r && (capKind_r ? (bitCnt_r == 6'd40) : (bitCnt_r == 6'd24));

   always_comb begin
      capTgl_nxt = capTgl_r ^ frameOk;
      wrEnVol_nxt = (opcode_r == VCR_OP_WREN_VOL && bitCnt_r == 6'd8) ? 1'b1 :
                    (frameOk ? 1'b0 : wrEnVol_r);
   end

   always_ff @(posedge csN or posedge rst) begin
      if (rst) begin
         capTgl_r <= 1'b0;
         wrEnVol_r <= 1'b0;
         txByte_r <= VCR_RST_BYTE;
      end else begin
         capTgl_r <= capTgl_nxt;
         wrEnVol_r <= wrEnVol_nxt;
         txByte_r <= capByte_r;
      end
   end

   // Read path: register value crossed by two flops into link domain
   always_comb begin
      readSnap1_nxt = cfgOne;
      readSnap2_nxt = readSnap1_r;
   end

   logic [7:0] outSh_r, outSh_nxt;
   logic oe_r, oe_nxt;
   always_comb begin
      outSh_nxt = {outSh_r[6:0], 1'b0};
      oe_nxt = oe_r;
      // Opcode 35h and read-any at our address return the volatile byte
      if ((opcode_r == VCR_OP_READ_CFG1 && bitCnt_r == 6'd8) ||
          (opcode_r == VCR_OP_READ_ANY && bitCnt_r == 6'd32 &&
           shift_r[23:0] == VCR_ADDR_CFG1)) begin
         outSh_nxt = readSnap2_r;
         oe_nxt = 1'b1;
      end
   end

   always_ff @(negedge spiClk or posedge csN) begin
      if (csN) begin
         outSh_r <= 8'h00;
         oe_r <= 1'b0;
         readSnap1_r <= 8'h00;
         readSnap2_r <= 8'h00;
      end else begin
         outSh_r <= outSh_nxt;
         oe_r <= oe_nxt;
         readSnap1_r <= readSnap1_nxt;
         readSnap2_r <= readSnap2_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Core register
   // ----------------------------------------------------------------
   logic [2:0] tglSync_r, tglSync_nxt;
   logic inv_r, inv_nxt, quad_r, quad_nxt, guard_r, guard_nxt;
   logic [1:0] loadWait_r, loadWait_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   vcr_status_t stat_r, stat_nxt;
   logic gwOk_r, gwOk_nxt, l3Data_r, l3Data_nxt, hwRstN_r, hwRstN_nxt;
   logic miso_r, misoOe_r;
   logic commit;
   logic [7:0] wbyte;

   assign commit = tglSync_r[2] ^ tglSync_r[1];

   always_comb begin
      tglSync_nxt = {tglSync_r[1:0], capTgl_r};
      wbyte = txByte_r & VCR_WRITE_MASK;
      inv_nxt = inv_r;
      quad_nxt = quad_r;
      guard_nxt = guard_r;
      loadWait_nxt = (loadWait_r == VCR_LOAD_WAIT) ? loadWait_r : loadWait_r + 2'h1;
      if (loadWait_r != VCR_LOAD_WAIT || loadDefaults) begin
         // Reloaded until the defaults have passed both synchroniser stages
         inv_nxt = defS2_r.invertDefault;
         quad_nxt = defS2_r.widthDefault;
         guard_nxt = defS2_r.guardDefault;
      end else if (commit && gwOk_r) begin
         // Read-only bits masked off; writable bits updated together
         inv_nxt = wbyte[VCR_BIT_INV];
         quad_nxt = wbyte[VCR_BIT_QUAD];
         guard_nxt = wbyte[VCR_BIT_GUARD];
      end
      // Software reset never clears the guard
      if (swReset) begin
         inv_nxt = defS2_r.invertDefault;
         quad_nxt = defS2_r.widthDefault;
      end
      cfg_nxt = {defS2_r.suspended, inv_nxt, defS2_r.regionLock, quad_nxt, guard_nxt};
      stat_nxt.protInvert = inv_nxt;
      stat_nxt.quadActive = quad_nxt | fourLineInstr;
      stat_nxt.wpInternalN = quad_nxt | fourLineInstr | wpSync_r[1];
      stat_nxt.guardSticky = guard_nxt;
      // Guard set rejects all; else pin-mode protects while wpInternalN is low (pin low and not quad)
      gwOk_nxt = !guard_nxt && !(guardPinMode && !stat_nxt.wpInternalN);
      // Line 3 is data inside frames in quad, reset input otherwise
      l3Data_nxt = stat_nxt.quadActive && !csSync_r[1];
      hwRstN_nxt = l3Data_nxt | l3Sync_r[1];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tglSync_r <= 3'h0;
         inv_r <= 1'b0;
         quad_r <= 1'b0;
         guard_r <= 1'b0;
         loadWait_r <= 2'h0;
         cfg_r <= VCR_RST_BYTE;
         stat_r <= '{protInvert: 1'b0, quadActive: 1'b0, wpInternalN: 1'b1, guardSticky: 1'b0};
         gwOk_r <= 1'b0;
         l3Data_r <= 1'b0;
         hwRstN_r <= 1'b1;
      end else begin
         tglSync_r <= tglSync_nxt;
         inv_r <= inv_nxt;
         quad_r <= quad_nxt;
         guard_r <= guard_nxt;
         loadWait_r <= loadWait_nxt;
         cfg_r <= cfg_nxt;
         stat_r <= stat_nxt;
         gwOk_r <= gwOk_nxt;
         l3Data_r <= l3Data_nxt;
         hwRstN_r <= hwRstN_nxt;
      end
   end

   always_ff @(negedge spiClk or posedge csN) begin
      if (csN) begin
         miso_r <= 1'b0;
         misoOe_r <= 1'b0;
      end else begin
         miso_r <= outSh_nxt[7];
         misoOe_r <= oe_nxt;
      end
   end

   assign misoOut = miso_r;
   assign misoOe = misoOe_r;
   assign cfgOne = cfg_r;
   assign status = stat_r;
   assign guardedWriteOk = gwOk_r;
   assign line3IsData = l3Data_r;
   assign hwResetN = hwRstN_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_guard_sticky;
      @(posedge core_clk) disable iff (rst)
         (loadWait_r == VCR_LOAD_WAIT && guard_r && !loadDefaults) |=> guard_r;
   endproperty
   a_guard_sticky: assert property (p_guard_sticky) else $error("guard cleared");

   property p_wp_inactive;
      @(posedge core_clk) disable iff (rst)
         quad_r |-> stat_r.wpInternalN;
   endproperty
   a_wp_inactive: assert property (p_wp_inactive) else $error("wp active in quad");

   property p_guard_blocks;
      @(posedge core_clk) disable iff (rst)
         stat_r.guardSticky |-> !guardedWriteOk;
   endproperty
   a_guard_blocks: assert property (p_guard_blocks) else $error("guarded write allowed");

   property p_sus_ro;
      @(posedge core_clk) disable iff (rst)
         cfg_r[VCR_BIT_SUS] == $past(defS2_r.suspended);
   endproperty
   a_sus_ro: assert property (p_sus_ro) else $error("suspend bit wrong");

   property p_lock_mirror;
      @(posedge core_clk) disable iff (rst)
         cfg_r[5:2] == $past(defS2_r.regionLock);
   endproperty
   a_lock_mirror: assert property (p_lock_mirror) else $error("lock mirror wrong");

   property p_four_line;
      @(posedge core_clk) disable iff (rst)
         fourLineInstr |=> stat_r.quadActive;
   endproperty
   a_four_line: assert property (p_four_line) else $error("width not forced");

   property p_no_commit_guarded;
      @(posedge core_clk) disable iff (rst)
         (commit && !gwOk_r && loadWait_r == VCR_LOAD_WAIT && !loadDefaults && !swReset)
            |=> $stable(quad_r);
   endproperty
   a_no_commit_guarded: assert property (p_no_commit_guarded) else $error("write passed guard");

   property p_line3;
      @(posedge core_clk) disable iff (rst)
         line3IsData |-> stat_r.quadActive;
   endproperty
   a_line3: assert property (p_line3) else $error("line3 data without quad");
endmodule

// ### core/vcr_pkg.sv
package vcr_pkg;
   // Command opcodes
   localparam logic [7:0] VCR_OP_READ_CFG1 = 8'h35;
   localparam logic [7:0] VCR_OP_WREN_VOL = 8'h50;
   localparam logic [7:0] VCR_OP_WRITE_REGS = 8'h01;
   localparam logic [7:0] VCR_OP_READ_ANY = 8'h65;
   localparam logic [7:0] VCR_OP_WRITE_ANY = 8'h71;
   // Field positions in volatile_config_one
   localparam int VCR_BIT_SUS = 7;
   localparam int VCR_BIT_INV = 6;
   localparam int VCR_BIT_LOCK_LO = 2;
   localparam int VCR_BIT_QUAD = 1;
   localparam int VCR_BIT_GUARD = 0;
   // Address of this register for the any-register commands
   localparam logic [23:0] VCR_ADDR_CFG1 = 24'h00_0002;
   // Reset value of internal control state
   localparam logic [7:0] VCR_RST_BYTE = 8'h00;
   // Core cycles spent reloading defaults after reset release
   localparam logic [1:0] VCR_LOAD_WAIT = 2'h3;
   // Bits the host may write (inverted map, quad, guard)
   localparam logic [7:0] VCR_WRITE_MASK = 8'h43;

   typedef struct packed {
      logic suspended;
      logic invertDefault;
      logic [3:0] regionLock;
      logic widthDefault;
      logic guardDefault;
   } vcr_defaults_t;

   typedef struct packed {
      logic protInvert;
      logic quadActive;
      logic wpInternalN;
      logic guardSticky;
   } vcr_status_t;
endpackage

// ### verif/vcr_spi_host.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Host end of the serial link, mode 0
// ---------------------------------------------
module vcr_spi_host (
   output logic spiClk,
   output logic csN,
   output logic mosi,
   input wire logic misoOut,
   input wire logic misoOe
);
   initial begin
      spiClk = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
   end

   // Clock stands still between frames; released data line is flipped so no stale bit lingers
   // Only single-line commands are sent, so no quad read ever precedes the quad bit
   task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rx);
      rx = 8'h00;
      #37 csN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = d[i];
         #80 spiClk = 1'b1;
         rx = {rx[6:0], (misoOe === 1'b1) ? misoOut : 1'bx};
         #80 spiClk = 1'b0;
      end
      #80 csN = 1'b1;
      mosi = ~mosi;
      // Gap covers the commit time, so the next command may follow at once
      #400;
   endtask
endmodule

// ### verif/volatile_config_register_one_tb_top.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Register access through serial commands
// ---------------------------------------------
module volatile_config_register_one_tb_top;
   import vcr_pkg::*;
   logic core_clk, rst, swReset, loadDefaults, fourLineInstr, guardPinMode, wpPinIn;
   logic line3PinIn, spiClk, csN, mosi, misoOut, misoOe, guardedWriteOk, line3IsData;
   logic hwResetN;
   logic [7:0] cfgOne, rx;
   vcr_defaults_t defaults;
   vcr_status_t status;
   int failures = 0;
   int num_checks = 0;

   vcr_config_one vcr_config_one_i (.core_clk(core_clk), .rst(rst), .swReset(swReset),
      .loadDefaults(loadDefaults), .defaults(defaults), .fourLineInstr(fourLineInstr),
      .guardPinMode(guardPinMode), .spiClk(spiClk), .csN(csN), .mosi(mosi),
      .wpPinIn(wpPinIn), .line3PinIn(line3PinIn), .misoOut(misoOut), .misoOe(misoOe),
      .cfgOne(cfgOne), .status(status), .guardedWriteOk(guardedWriteOk),
      .line3IsData(line3IsData), .hwResetN(hwResetN));

   vcr_spi_host vcr_spi_host_i (.spiClk(spiClk), .csN(csN), .mosi(mosi),
      .misoOut(misoOut), .misoOe(misoOe));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic wen;
      vcr_spi_host_i.frame({32'h0000_0000, VCR_OP_WREN_VOL}, 8, rx);
   endtask

   task automatic wany(input logic [23:0] a, input logic [7:0] v);
      wen();
      vcr_spi_host_i.frame({VCR_OP_WRITE_ANY, a, v}, 40, rx);
   endtask

   // Register value, both read commands and the decoded status must agree
   task automatic chkAll(input logic [7:0] e);
      chk(cfgOne, e);
      vcr_spi_host_i.frame({24'h00_0000, VCR_OP_READ_CFG1, 8'h00}, 16, rx);
      chk(rx, e);
      vcr_spi_host_i.frame({VCR_OP_READ_ANY, VCR_ADDR_CFG1, 8'h00}, 40, rx);
      chk(rx, e);
      chk({5'h00, status.protInvert, status.quadActive, status.guardSticky},
         {5'h00, e[6], e[1] | fourLineInstr, e[0]});
   endtask

   initial begin
      #1_000_000;
      failures++;
      end_of_test();
   end

   initial begin
      rst = 1'b1;
      swReset = 1'b0;
      loadDefaults = 1'b0;
      fourLineInstr = 1'b0;
      guardPinMode = 1'b0;
      wpPinIn = 1'b1;
      line3PinIn = 1'b1;
      defaults = vcr_defaults_t'(8'h68);
      idle(3);
      rst = 1'b0;
      idle(10);
      chkAll(8'h68);
      wany(VCR_ADDR_CFG1, 8'h42);
      // No enable frame ahead of this write, so it must be dropped
      vcr_spi_host_i.frame({VCR_OP_WRITE_ANY, VCR_ADDR_CFG1, 8'h02}, 40, rx);
      chk(cfgOne, 8'h6A);
      wany(VCR_ADDR_CFG1, 8'h68);
      wen();
      vcr_spi_host_i.frame({16'h0000, VCR_OP_WRITE_REGS, 8'hFF, 8'hBE}, 24, rx);
      chkAll(8'h2A);
      fork
         vcr_spi_host_i.frame({24'h00_0000, VCR_OP_READ_CFG1, 8'h00}, 16, rx);
         begin
            #1000 chk({6'h00, hwResetN, line3IsData}, 8'h03);
         end
      join
      wen();
      vcr_spi_host_i.frame({20'h0_0000, VCR_OP_WRITE_REGS, 8'h00, 4'h0}, 20, rx);
      wany(24'h00_0003, 8'h00);
      chk(cfgOne, 8'h2A);
      wany(VCR_ADDR_CFG1, 8'h41);
      chkAll(8'h69);
      chk({7'h00, guardedWriteOk}, 8'h00);
      wany(VCR_ADDR_CFG1, 8'h02);
      chk(cfgOne, 8'h69);
      defaults = vcr_defaults_t'(8'h96);
      idle(10);
      chk(cfgOne, 8'hD5);
      swReset = 1'b1;
      idle(1);
      swReset = 1'b0;
      idle(10);
      chkAll(8'h97);
      idle(1);
      wpPinIn = 1'b0;
      line3PinIn = 1'b0;
      guardPinMode = 1'b1;
      idle(10);
      chk({4'h0, status.wpInternalN, hwResetN, line3IsData, guardedWriteOk}, 8'h08);
      line3PinIn = 1'b1;
      loadDefaults = 1'b1;
      idle(1);
      loadDefaults = 1'b0;
      idle(10);
      chk(cfgOne, 8'h96);
      chk({7'h00, guardedWriteOk}, 8'h01);
      wany(VCR_ADDR_CFG1, 8'h00);
      chkAll(8'h94);
      chk({7'h00, guardedWriteOk}, 8'h00);
      wany(VCR_ADDR_CFG1, 8'h40);
      chk(cfgOne, 8'h94);
      wpPinIn = 1'b1;
      idle(10);
      chk({7'h00, guardedWriteOk}, 8'h01);
      fourLineInstr = 1'b1;
      idle(10);
      chkAll(8'h94);
      end_of_test();
   end
endmodule
